// >>> rtl/terminal_select_pkg.sv
// Shared constants and types for the output terminal function select block.
// Assumes a single 125 MHz clock and an APB register port with 32-bit data.
package terminal_select_pkg;

	localparam int NUM_TERM = 7;
	localparam int NUM_FUNC = 100;
	localparam int CODE_W   = 8;
	localparam int FREQ_W   = 16;

	// Codes below NEG_BASE conduct when active, codes from NEG_BASE up to CODE_LIMIT do not.
	localparam logic [7:0] NEG_BASE   = 8'h64;
	localparam logic [7:0] CODE_LIMIT = 8'hc8;

	// Function indices; the negative form of each is the index plus NEG_BASE.
	localparam logic [6:0] F_RUN    = 7'h00;
	localparam logic [6:0] F_SU     = 7'h01;
	localparam logic [6:0] F_IPF    = 7'h02;
	localparam logic [6:0] F_OL     = 7'h03;
	localparam logic [6:0] F_FU     = 7'h04;
	localparam logic [6:0] F_FU2    = 7'h05;
	localparam logic [6:0] F_FU3    = 7'h06;
	localparam logic [6:0] F_LIFE   = 7'h5a;
	localparam logic [6:0] F_PWROFF = 7'h5b;
	localparam logic [6:0] F_EAVG   = 7'h5c;
	localparam logic [6:0] F_PULSE  = 7'h5d;
	localparam logic [6:0] F_HELD   = 7'h5e;
	localparam logic [6:0] F_MAINT  = 7'h5f;
	localparam logic [6:0] F_REMOTE = 7'h60;
	localparam logic [6:0] F_SECOND = 7'h61;
	localparam logic [6:0] F_MINOR  = 7'h62;
	localparam logic [6:0] F_MAJOR  = 7'h63;

	// Terminal order; the last two are relay contacts.
	localparam int T_RUN         = 0;
	localparam int T_SU          = 1;
	localparam int T_FU          = 4;
	localparam int T_RELAY_FIRST = 5;

	localparam logic [6:0][7:0] SEL_RESET = {8'h63, 8'h63, 8'h04, 8'h03, 8'h02, 8'h01, 8'h00};

	localparam logic [11:0] A_SEL0    = 12'h000;
	localparam logic [11:0] A_CTRL    = 12'h01c;
	localparam logic [11:0] A_REMOTE  = 12'h020;
	localparam logic [11:0] A_MCOUNT  = 12'h024;
	localparam logic [11:0] A_MTHRESH = 12'h028;
	localparam logic [11:0] A_DETECT  = 12'h02c;
	localparam logic [11:0] A_STATUS  = 12'h030;

	localparam int CTRL_ALARM_CODE = 0;
	localparam int CTRL_FAULT_SEL  = 1;

	typedef struct packed {
		logic [89:0]       base_func;
		logic              life_warn;
		logic              circuit_fail;
		logic              conn_fault;
		logic              energy_refresh;
		logic              energy_mon_on;
		logic              avg_pulse;
		logic              protect_stop;
		logic              ctl_reset;
		logic              supply_off;
		logic              overheat_decel;
		logic              fan_fail;
		logic              comm_warn;
		logic              alarm_active;
		logic [3:0]        alarm_code;
		logic              encoder_mode;
		logic [FREQ_W-1:0] enc_speed;
		logic [FREQ_W-1:0] out_freq;
		logic              su_in;
		logic              fu_in;
		logic              fu2_in;
		logic              fu3_in;
	} drive_status_s;

endpackage

// >>> rtl/function_vector.sv
// Builds the vector of status functions that the terminals select from.
// Assumes the status inputs are synchronous to clk; the held fault, the energy toggle and the delayed reset are the only state here.
`timescale 1ns/1ps
`default_nettype none
module function_vector (
	input  wire logic                                clk,
	input  wire logic                                rst_n,
	input  wire terminal_select_pkg::drive_status_s  st,
	input  wire logic                                fault_sel,
	input  wire logic [15:0]                         mcount,
	input  wire logic [15:0]                         mthresh,
	input  wire logic [15:0]                         det1,
	input  wire logic [15:0]                         det2,
	output logic [terminal_select_pkg::NUM_FUNC-1:0] func
);
	typedef struct packed {
		logic held;
		logic toggle;
		logic reset_d;
	} fv_state_s;

	fv_state_s s;
	fv_state_s next_s;

	always_comb begin
		next_s = s;
		next_s.reset_d = st.ctl_reset;
		if (st.energy_refresh && st.energy_mon_on) begin
			next_s.toggle = !s.toggle; // [R6]
		end
		// Supply loss drops the held fault at once; a new fault beats a reset release.
		if (st.supply_off) begin
			next_s.held = 1'b0; // [R9]
		end else if (st.protect_stop) begin
			next_s.held = 1'b1; // [R8]
		end else if (s.reset_d && !st.ctl_reset) begin
			next_s.held = 1'b0; // [R8]
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	always_comb begin
		func = '0;
		func[89:0] = st.base_func;
		if (st.encoder_mode) begin
			func[terminal_select_pkg::F_SU]  = st.enc_speed > det1; // [R17]
			func[terminal_select_pkg::F_FU]  = st.enc_speed > det1; // [R17]
			func[terminal_select_pkg::F_FU2] = st.out_freq > det2; // [R18]
			func[terminal_select_pkg::F_FU3] = st.out_freq > det2; // [R18]
		end else begin
			func[terminal_select_pkg::F_SU]  = st.su_in;
			func[terminal_select_pkg::F_FU]  = st.fu_in;
			func[terminal_select_pkg::F_FU2] = st.fu2_in;
			func[terminal_select_pkg::F_FU3] = st.fu3_in;
		end
		func[terminal_select_pkg::F_LIFE]   = st.life_warn; // [R4]
		func[terminal_select_pkg::F_PWROFF] = st.circuit_fail || st.conn_fault; // [R5]
		func[terminal_select_pkg::F_EAVG]   = s.toggle; // [R6]
		func[terminal_select_pkg::F_PULSE]  = st.avg_pulse; // [R7]
		func[terminal_select_pkg::F_HELD]   = s.held; // [R8]
		func[terminal_select_pkg::F_MAINT]  = mcount >= mthresh; // [R10]
		func[terminal_select_pkg::F_SECOND] = st.protect_stop || (fault_sel && st.overheat_decel); // [R12]
		func[terminal_select_pkg::F_MINOR]  = st.fan_fail || st.comm_warn; // [R13]
		func[terminal_select_pkg::F_MAJOR]  = st.protect_stop && !st.ctl_reset; // [R14]
	end

	property p_held_through_reset;
		@(posedge clk) disable iff (!rst_n)
		(s.held && st.ctl_reset && !st.supply_off) |=> s.held;
	endproperty
	a_held_through_reset: assert property (p_held_through_reset) else $error("held fault lost during reset"); // [R8]

	property p_held_supply_off;
		@(posedge clk) disable iff (!rst_n)
		st.supply_off |=> !s.held;
	endproperty
	a_held_supply_off: assert property (p_held_supply_off) else $error("held fault kept after supply off"); // [R9]
endmodule
`default_nettype wire

// >>> rtl/terminal_decode.sv
// Decodes one terminal selection code against the function vector.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
module terminal_decode (
	input  wire logic [7:0]                                code,
	input  wire logic [terminal_select_pkg::NUM_FUNC-1:0] func,
	input  wire logic                                      remote_bit,
	input  wire logic                                      is_relay,
	output logic                                           conduct
);
	logic       neg;
	logic       valid;
	logic       active;
	logic [7:0] idx;

	always_comb begin
		neg = code >= terminal_select_pkg::NEG_BASE;
		idx = neg ? code - terminal_select_pkg::NEG_BASE : code;
		valid = code < terminal_select_pkg::CODE_LIMIT; // [R2]
		if (is_relay && idx[6:0] == terminal_select_pkg::F_PULSE) begin
			valid = 1'b0; // [R7]
		end
		active = 1'b0;
		if (valid) begin
			if (idx[6:0] == terminal_select_pkg::F_REMOTE) begin
				active = remote_bit; // [R11]
			end else begin
				active = func[idx[6:0]];
			end
		end
		conduct = valid && (active ^ neg); // [R1]
	end
endmodule
`default_nettype wire

// >>> rtl/output_terminal_function_select.sv
// Output terminal function select: seven terminals, each steered by a code register.
// Assumes an APB master on clk and drive status inputs synchronous to clk.
//
// Summary of operation
// (R1) Codes 0-99 conduct when active; codes 100-199 do not conduct when active.
// (R2) A code outside both ranges gives no function output.
// (R3) One function may drive several terminals, each independently.
// (R4) Code 90/190 shows life warning of capacitors, inrush limiter or fan.
// (R5) Code 91/191 shows power-off alarm on circuit failure or connection fault.
// (R6) Code 92/192 toggles on each energy average refresh while monitoring.
// (R7) Code 93/193 outputs average pulse trains; refused on relay terminals.
// (R8) Code 94/194 holds major fault through reset, clearing on reset release.
// (R9) Held fault drops at once when the supply switches off.
// (R10) Code 95/195 asserts once maintenance counter reaches threshold.
// (R11) Code 96/196 drives the terminal from the software remote bit.
// (R12) Code 97/197 is major fault, or with select 1 also overheat deceleration.
// (R13) Code 98/198 shows minor fault on fan failure or communication warning.
// (R14) Code 99/199 is major alarm, dropped as soon as reset is active.
// (R15) Alarm code select 1 puts alarm code on SU, POWER_FAILURE_OUT, OL, FU during alarms.
// (R16) RUN terminal and relays ignore the alarm code select.
// (R17) Encoder mode: SU and FU compare encoder speed to the detect setting.
// (R18) Encoder mode: FU2 and FU3 compare output frequency to the detect setting.
// (R19) Users should not route fast-toggling functions to relay terminals.
// (R20) Terminal outputs are registered and reset to non-conducting.
`timescale 1ns/1ps
`default_nettype none
module output_terminal_function_select (
	input  wire logic                                clk,
	input  wire logic                                resetn,
	input  wire logic [11:0]                         paddr,
	input  wire logic                                psel,
	input  wire logic                                penable,
	input  wire logic                                pwrite,
	input  wire logic [31:0]                         pwdata,
	output logic [31:0]                              prdata,
	output logic                                     pready,
	output logic                                     pslverr,
	input  wire terminal_select_pkg::drive_status_s  status,
	output logic [terminal_select_pkg::NUM_TERM-1:0] term_conduct
);
	typedef struct packed {
		logic [6:0][7:0] sel;
		logic            alarm_code_output_select;
		logic            fault_output_select;
		logic [6:0]      remote_out;
		logic [15:0]     maintenance_counter;
		logic [15:0]     maintenance_threshold;
		logic [15:0]     det1;
		logic [15:0]     det2;
		logic [6:0]      term;
		logic [31:0]     rdata;
		logic            err;
	} regs_s;

	logic [1:0] rst_pipe;
	logic       rst_n;

	regs_s r;
	regs_s next_r;

	logic [terminal_select_pkg::NUM_FUNC-1:0] func;
	logic [terminal_select_pkg::NUM_TERM-1:0] decoded;
	logic [terminal_select_pkg::NUM_TERM-1:0] next_term;

	logic        setup;
	logic        wr_access;
	logic        sel_hit;
	logic [2:0]  sel_idx;
	logic [11:0] sel_end;

	// The reset is released through two flops so that every flop leaves reset on the same edge.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_pipe <= 2'b00;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end
	assign rst_n = rst_pipe[1];

	function_vector u_func (
		.clk       (clk),
		.rst_n     (rst_n),
		.st        (status),
		.fault_sel (r.fault_output_select),
		.mcount    (r.maintenance_counter),
		.mthresh   (r.maintenance_threshold),
		.det1      (r.det1),
		.det2      (r.det2),
		.func      (func)
	);

	// The function vector is shared, so any number of terminals may pick the same entry.
	genvar gi;
	generate
		for (gi = 0; gi < terminal_select_pkg::NUM_TERM; gi++) begin : g_term
			terminal_decode u_dec (
				.code       (r.sel[gi]),
				.func       (func), // [R3]
				.remote_bit (r.remote_out[gi]),
				.is_relay   (gi >= terminal_select_pkg::T_RELAY_FIRST),
				.conduct    (decoded[gi])
			);
			if (gi >= terminal_select_pkg::T_SU && gi <= terminal_select_pkg::T_FU) begin : g_alarm
				always_comb begin
					if (r.alarm_code_output_select && status.alarm_active) begin
						next_term[gi] = status.alarm_code[gi - terminal_select_pkg::T_SU]; // [R15]
					end else begin
						next_term[gi] = decoded[gi];
					end
				end
			end else begin : g_plain
				// RUN and the relays never take the alarm code.
				always_comb begin
					next_term[gi] = decoded[gi]; // [R16]
				end
			end
		end
	endgenerate

	assign setup = psel && !penable;
	assign wr_access = psel && penable && pwrite;
	assign sel_end = terminal_select_pkg::A_CTRL;
	assign sel_hit = paddr < sel_end && paddr[1:0] == 2'b00;
	assign sel_idx = paddr[4:2];

	always_comb begin
		next_r = r;
		next_r.term = next_term; // [R20]
		if (setup) begin
			next_r.rdata = '0;
			next_r.err = 1'b0;
			if (sel_hit) begin
				next_r.rdata[7:0] = r.sel[sel_idx];
			end else if (paddr == terminal_select_pkg::A_CTRL) begin
				next_r.rdata[terminal_select_pkg::CTRL_ALARM_CODE] = r.alarm_code_output_select;
				next_r.rdata[terminal_select_pkg::CTRL_FAULT_SEL] = r.fault_output_select;
			end else if (paddr == terminal_select_pkg::A_REMOTE) begin
				next_r.rdata[6:0] = r.remote_out;
			end else if (paddr == terminal_select_pkg::A_MCOUNT) begin
				next_r.rdata[15:0] = r.maintenance_counter;
			end else if (paddr == terminal_select_pkg::A_MTHRESH) begin
				next_r.rdata[15:0] = r.maintenance_threshold;
			end else if (paddr == terminal_select_pkg::A_DETECT) begin
				next_r.rdata = {r.det2, r.det1};
			end else if (paddr == terminal_select_pkg::A_STATUS) begin
				next_r.rdata[6:0] = r.term;
				next_r.rdata[7] = func[terminal_select_pkg::F_HELD];
				next_r.rdata[8] = func[terminal_select_pkg::F_EAVG];
				next_r.rdata[9] = func[terminal_select_pkg::F_MAINT];
			end else begin
				next_r.err = 1'b1;
			end
		end
		// Writes land on the access edge; the status word is read only.
		if (wr_access) begin
			if (sel_hit) begin
				next_r.sel[sel_idx] = pwdata[7:0];
			end else if (paddr == terminal_select_pkg::A_CTRL) begin
				next_r.alarm_code_output_select = pwdata[terminal_select_pkg::CTRL_ALARM_CODE];
				next_r.fault_output_select = pwdata[terminal_select_pkg::CTRL_FAULT_SEL];
			end else if (paddr == terminal_select_pkg::A_REMOTE) begin
				next_r.remote_out = pwdata[6:0]; // [R11]
			end else if (paddr == terminal_select_pkg::A_MCOUNT) begin
				next_r.maintenance_counter = pwdata[15:0];
			end else if (paddr == terminal_select_pkg::A_MTHRESH) begin
				next_r.maintenance_threshold = pwdata[15:0];
			end else if (paddr == terminal_select_pkg::A_DETECT) begin
				next_r.det1 = pwdata[15:0];
				next_r.det2 = pwdata[31:16];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
			r.sel <= terminal_select_pkg::SEL_RESET;
		end else begin
			r <= next_r;
		end
	end

	// Read data is captured in the setup cycle, so every transfer ends in its first access cycle.
	assign pready = psel && penable;
	assign prdata = r.rdata;
	assign pslverr = r.err;
	assign term_conduct = r.term;

	property p_positive_remote;
		@(posedge clk) disable iff (!rst_n)
		(r.sel[0] == {1'b0, terminal_select_pkg::F_REMOTE} && !wr_access) |=> term_conduct[0] == $past(r.remote_out[0]);
	endproperty
	a_positive_remote: assert property (p_positive_remote) else $error("positive remote code not followed"); // [R11]

	property p_negative_remote;
		@(posedge clk) disable iff (!rst_n)
		(r.sel[0] == terminal_select_pkg::NEG_BASE + {1'b0, terminal_select_pkg::F_REMOTE} && !wr_access)
			|=> term_conduct[0] != $past(r.remote_out[0]);
	endproperty
	a_negative_remote: assert property (p_negative_remote) else $error("negative code did not invert"); // [R1]

	property p_invalid_code;
		@(posedge clk) disable iff (!rst_n)
		(r.sel[0] >= terminal_select_pkg::CODE_LIMIT && !wr_access) |=> !term_conduct[0];
	endproperty
	a_invalid_code: assert property (p_invalid_code) else $error("invalid code drove a terminal"); // [R2]

	property p_relay_pulse;
		@(posedge clk) disable iff (!rst_n)
		(r.sel[terminal_select_pkg::T_RELAY_FIRST] == {1'b0, terminal_select_pkg::F_PULSE} && !wr_access)
			|=> !term_conduct[terminal_select_pkg::T_RELAY_FIRST];
	endproperty
	a_relay_pulse: assert property (p_relay_pulse) else $error("pulse code accepted on a relay"); // [R7]

	property p_shared_function;
		@(posedge clk) disable iff (!rst_n)
		(r.sel[5] == r.sel[6] && r.remote_out[5] == r.remote_out[6] && !wr_access)
			|=> term_conduct[5] == term_conduct[6];
	endproperty
	a_shared_function: assert property (p_shared_function) else $error("same code gave different relay outputs"); // [R3]

	property p_alarm_code;
		@(posedge clk) disable iff (!rst_n)
		(r.alarm_code_output_select && status.alarm_active) |=> term_conduct[4:1] == $past(status.alarm_code);
	endproperty
	a_alarm_code: assert property (p_alarm_code) else $error("alarm code not on the four terminals"); // [R15]

	property p_run_kept;
		@(posedge clk) disable iff (!rst_n)
		(r.alarm_code_output_select && r.sel[0] == {1'b0, terminal_select_pkg::F_REMOTE} && !wr_access)
			|=> term_conduct[0] == $past(r.remote_out[0]);
	endproperty
	a_run_kept: assert property (p_run_kept) else $error("run terminal changed by alarm code select"); // [R16]

	property p_maintenance;
		@(posedge clk) disable iff (!rst_n)
		(r.sel[0] == {1'b0, terminal_select_pkg::F_MAINT} && !wr_access)
			|=> term_conduct[0] == ($past(r.maintenance_counter) >= $past(r.maintenance_threshold));
	endproperty
	a_maintenance: assert property (p_maintenance) else $error("maintenance output wrong"); // [R10]

	property p_major_reset;
		@(posedge clk) disable iff (!rst_n)
		(r.sel[0] == {1'b0, terminal_select_pkg::F_MAJOR} && status.ctl_reset && !wr_access) |=> !term_conduct[0];
	endproperty
	a_major_reset: assert property (p_major_reset) else $error("major alarm kept during reset"); // [R14]

	property p_encoder_su;
		@(posedge clk) disable iff (!rst_n)
		(r.sel[1] == {1'b0, terminal_select_pkg::F_SU} && status.encoder_mode && !status.alarm_active && !wr_access)
			|=> term_conduct[1] == ($past(status.enc_speed) > $past(r.det1));
	endproperty
	a_encoder_su: assert property (p_encoder_su) else $error("encoder speed compare wrong"); // [R17]

	property p_apb_ready;
		@(posedge clk) disable iff (!rst_n)
		(psel && !penable) ##1 (psel && penable) |-> pready;
	endproperty
	a_apb_ready: assert property (p_apb_ready) else $error("access phase not answered"); // [R20]
endmodule
`default_nettype wire

// >>> bench/terminal_reader.sv
// Model of the external equipment that reads the seven output terminals.
// Assumes the terminal levels are registered on clk inside the block.
`timescale 1ns/1ps
`default_nettype none
module terminal_reader (
	input  wire logic       clk,
	input  wire logic [6:0] term_conduct,
	output var  logic [6:0] seen,
	output var  int         relay_flips
);
	// The equipment only listens; it latches every terminal once a clock and drives nothing back.
	initial relay_flips = 0;
	always @(posedge clk) begin
		seen <= term_conduct;
		// Relay contacts wear with each change, so the bench keeps fast functions off them.
		if (seen[6:5] != term_conduct[6:5])
			relay_flips <= relay_flips + 1;
	end
endmodule
`default_nettype wire

// >>> bench/output_terminal_function_select_bench.sv
// Self-checking bench for the output terminal function select block.
// Assumes the design package and the reader model in terminal_reader.sv.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module output_terminal_function_select_bench;
	typedef struct {
		string       nm;
		int          kind;
		logic [31:0] exp;
		logic [31:0] mask;
	} note_s;
	logic                               clk = 1'b0;
	logic                               resetn = 1'b0;
	logic [11:0]                        paddr = 12'h000;
	logic                               psel = 1'b0;
	logic                               penable = 1'b0;
	logic                               pwrite = 1'b0;
	logic [31:0]                        pwdata = 32'h0;
	logic [31:0]                        prdata;
	logic                               pready;
	logic                               pslverr;
	terminal_select_pkg::drive_status_s st = '0;
	logic [6:0]                         term_conduct;
	logic [6:0]                         seen;
	int                                 relay_flips;
	logic [31:0]                        rd;
	logic                               rd_err;
	logic [31:0]                        r;
	logic [31:0]                        t;
	int                                 err_total = 0;
	int                                 cmp_count = 0;
	int                                 cyc = 0;
	note_s                              notes[$];
	logic [7:0]                         code_tab[7] = '{8'h5a, 8'h5b, 8'h5b, 8'h62, 8'h62, 8'h63, 8'h61};

	always #4 clk = ~clk;

	output_terminal_function_select u_dut (.clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .status(st), .term_conduct(term_conduct));
	terminal_reader u_reader (.clk(clk), .term_conduct(term_conduct), .seen(seen), .relay_flips(relay_flips));

	// The watcher takes every pending expectation, oldest first, and compares it with what the reader or the last read shows now.
	always @(posedge clk) begin
		note_s       n;
		logic [31:0] g;
		while (notes.size() > 0) begin
			n = notes.pop_front();
			g = (n.kind == 0) ? {25'h0, seen} : (n.kind == 1) ? rd : {31'h0, rd_err};
			`CHK(n.nm, n.exp & n.mask, g & n.mask)
		end
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			conclude();
		end
	end

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= wr;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr_sel(input int i, input logic [7:0] c);
		apb(1'b1, terminal_select_pkg::A_SEL0 + 12'(4 * i), {24'h0, c});
	endtask

	// Waits long enough for the register, the reader and the watcher to settle.
	task automatic tchk(input string nm, input logic [6:0] e, input logic [6:0] m);
		repeat (3) @(posedge clk);
		// Pushing off the edge keeps the watcher from racing a fresh note.
		@(negedge clk);
		notes.push_back('{nm, 0, {25'h0, e}, {25'h0, m}});
		@(posedge clk);
	endtask

	task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e, input logic ee);
		apb(1'b0, a, 32'h0);
		notes.push_back('{nm, 1, e, 32'hffffffff});
		notes.push_back('{nm, 2, {31'h0, ee}, 32'h1});
		@(posedge clk);
	endtask

	task automatic setf(input int k, input logic v);
		case (k)
			0: st.life_warn <= v;
			1: st.circuit_fail <= v;
			2: st.conn_fault <= v;
			3: st.fan_fail <= v;
			4: st.comm_warn <= v;
			default: st.protect_stop <= v;
		endcase
	endtask

	initial begin
		void'($urandom(32'h8027));
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		rchk("unmapped", 12'h034, 32'h0, 1'b1);
		apb(1'b1, terminal_select_pkg::A_STATUS, 32'hffffffff);
		rchk("status", terminal_select_pkg::A_STATUS, 32'h200, 1'b0);
		$display("register test done");
		r = $urandom;
		for (int i = 0; i < 7; i++)
			wr_sel(i, 8'h60);
		apb(1'b1, terminal_select_pkg::A_REMOTE, r);
		tchk("remote_pos", r[6:0], 7'h7f);
		for (int i = 0; i < 7; i++)
			wr_sel(i, 8'hc4);
		tchk("remote_neg", ~r[6:0], 7'h7f);
		wr_sel(0, 8'hc8);
		wr_sel(1, 8'hff);
		tchk("invalid_code", {~r[6:2], 2'b00}, 7'h7f);
		$display("remote test done");
		for (int k = 0; k < 7; k++) begin
			wr_sel(0, code_tab[k]);
			wr_sel(1, code_tab[k] + 8'h64);
			setf(k, 1'b1);
			tchk("code_on", 7'h01, 7'h03);
			setf(k, 1'b0);
			tchk("code_off", 7'h02, 7'h03);
		end
		apb(1'b1, terminal_select_pkg::A_CTRL, 32'h2);
		st.overheat_decel <= 1'b1;
		tchk("fault_sel_one", 7'h01, 7'h03);
		st.overheat_decel <= 1'b0;
		apb(1'b1, terminal_select_pkg::A_CTRL, 32'h0);
		$display("fault code test done");
		wr_sel(0, 8'h63);
		wr_sel(1, 8'h5e);
		st.protect_stop <= 1'b1;
		tchk("fault_set", 7'h03, 7'h03);
		st.ctl_reset <= 1'b1;
		tchk("held_in_reset", 7'h02, 7'h03);
		st.protect_stop <= 1'b0;
		st.ctl_reset <= 1'b0;
		tchk("held_released", 7'h00, 7'h03);
		st.protect_stop <= 1'b1;
		tchk("refault", 7'h03, 7'h03);
		st.protect_stop <= 1'b0;
		st.supply_off <= 1'b1;
		tchk("supply_off", 7'h00, 7'h03);
		st.supply_off <= 1'b0;
		$display("held fault test done");
		wr_sel(2, 8'h5d);
		wr_sel(5, 8'h5d);
		st.avg_pulse <= 1'b1;
		tchk("pulse_relay", 7'h04, 7'h24);
		st.avg_pulse <= 1'b0;
		wr_sel(5, 8'h63);
		wr_sel(2, 8'h5c);
		st.energy_mon_on <= 1'b1;
		for (int p = 1; p <= 2; p++) begin
			st.energy_refresh <= 1'b1;
			@(posedge clk);
			st.energy_refresh <= 1'b0;
			tchk("energy_toggle", {4'h0, p[0], 2'b00}, 7'h04);
		end
		t = ($urandom % 32'hfffe) + 32'h1;
		wr_sel(3, 8'h5f);
		apb(1'b1, terminal_select_pkg::A_MTHRESH, t);
		apb(1'b1, terminal_select_pkg::A_MCOUNT, t - 32'h1);
		tchk("maint_below", 7'h00, 7'h08);
		apb(1'b1, terminal_select_pkg::A_MCOUNT, t);
		tchk("maint_reached", 7'h08, 7'h08);
		$display("monitor test done");
		wr_sel(1, 8'h01);
		wr_sel(2, 8'h05);
		wr_sel(3, 8'h06);
		wr_sel(4, 8'h04);
		apb(1'b1, terminal_select_pkg::A_DETECT, {t[15:0], t[15:0]});
		st.su_in <= 1'b1;
		st.fu_in <= 1'b1;
		st.encoder_mode <= 1'b1;
		st.enc_speed <= t[15:0];
		st.out_freq <= t[15:0] + 16'h1;
		tchk("encoder_equal", 7'h0c, 7'h1e);
		st.enc_speed <= t[15:0] + 16'h1;
		st.out_freq <= t[15:0];
		tchk("encoder_above", 7'h12, 7'h1e);
		wr_sel(0, 8'h60);
		wr_sel(5, 8'h60);
		wr_sel(6, 8'h60);
		apb(1'b1, terminal_select_pkg::A_REMOTE, 32'h61);
		apb(1'b1, terminal_select_pkg::A_CTRL, 32'h1);
		st.alarm_active <= 1'b1;
		st.alarm_code <= r[3:0];
		tchk("alarm_code", {2'b11, r[3:0], 1'b1}, 7'h7f);
		$display("routing test done");
		resetn <= 1'b0;
		tchk("reset_clear", 7'h00, 7'h7f);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		rchk("sel0_reset", terminal_select_pkg::A_SEL0, 32'h0, 1'b0);
		rchk("sel5_reset", terminal_select_pkg::A_SEL0 + 12'h014, 32'h63, 1'b0);
		$display("reset test done relay flips %0d", relay_flips);
		repeat (2) @(posedge clk);
		conclude();
	end
endmodule
`default_nettype wire
